// File: design/timer_capture_output_sync_pkg.sv
// constants for the timer capture, output and tuned operation channel
package timer_capture_output_sync_pkg;
  // ---------------------------------------------------------------
  // operating modes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [2:0] MODE_EVENT = 3'h1;
  localparam logic [2:0] MODE_TRIGGER = 3'h2;
  localparam logic [2:0] MODE_ONESHOT = 3'h3;
  localparam logic [2:0] MODE_PWM = 3'h4;
  localparam logic [2:0] MODE_FREE = 3'h5;
  localparam logic [2:0] MODE_PULSE_WIDTH = 3'h6;
  localparam logic [2:0] MODE_TRIANGLE = 3'h7;
  // ---------------------------------------------------------------
  // edge select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // ---------------------------------------------------------------
  // selector and option bit positions, reset values and counter limits
  // ---------------------------------------------------------------
  localparam int SEL_CH0_IN1_BIT = 2;
  localparam int SEL_CH1_IN0_BIT = 3;
  localparam int SEL_CH1_IN1_BIT = 4;
  localparam int OPT_FLAG_BIT = 0;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] OPT_RST = 8'h00;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CCR_RST = 16'h0000;
endpackage

// File: design/timer_capture_output_sync.sv
// one timer channel: capture, counter readback, overflow flag, outputs, tuned copy, capture source selector
`timescale 1ns/1ps
module timer_capture_output_sync #(
  parameter int unsigned CHANNEL = 1
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic count_enable_bit_i,
  input wire logic count_tick_i,
  input wire logic [2:0] mode_select_field_i,
  input wire logic [1:0] output_enable_bit_i,
  input wire logic [1:0] output_level_bit_i,
  input wire logic [1:0] edge_sel_0_i,
  input wire logic [1:0] edge_sel_1_i,
  input wire logic [1:0] ccr_is_capture_i,
  input wire logic capture_pin_0_i,
  input wire logic capture_pin_1_i,
  input wire logic uart_receive_0_i,
  input wire logic uart_receive_1_i,
  input wire logic interval_match_signal_i,
  input wire logic [1:0] ccr_wr_i,
  input wire logic [15:0] ccr_wdata_i,
  input wire logic opt_wr_i,
  input wire logic [7:0] opt_wdata_i,
  input wire logic ovf_bit_clr_i,
  input wire logic sel_wr_i,
  input wire logic [7:0] sel_wdata_i,
  input wire logic sync_enable_bit_i,
  input wire logic [2:0] master_mode_i,
  input wire logic [1:0] master_ccr_wr_i,
  input wire logic [15:0] master_wdata_i,
  input wire logic master_match_i,
  input wire logic [15:0] master_ccr_0_i,
  input wire logic [15:0] master_ccr_1_i,
  output logic timer_output_0_o,
  output logic timer_output_1_o,
  output logic [15:0] capcmp_reg_0_o,
  output logic [15:0] capcmp_reg_1_o,
  output logic [15:0] counter_read_buffer_o,
  output logic overflow_flag_o,
  output logic overflow_interrupt_o,
  output logic [1:0] capture_irq_o,
  output logic compare_match_o,
  output logic [7:0] option_reg_o,
  output logic [7:0] capture_source_select_reg_o
);
  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (CHANNEL > 3) begin : g_bad_channel
    $error("CHANNEL must be 0 to 3");
  end

  localparam bit IS_SLAVE = (CHANNEL == 1) || (CHANNEL == 3);

  typedef enum logic [1:0] {
    ST_STOP = 2'b01,
    ST_RUN = 2'b10
  } run_e;

  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    logic hit;
    hit = 1'b0;
    case (sel)
      timer_capture_output_sync_pkg::EDGE_RISE: hit = !prev && cur;
      timer_capture_output_sync_pkg::EDGE_FALL: hit = prev && !cur;
      timer_capture_output_sync_pkg::EDGE_BOTH: hit = prev ^ cur;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ---------------------------------------------------------------
  // input synchronisers and capture source selection
  // ---------------------------------------------------------------
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  logic [7:0] sel_ff;
  logic [7:0] nxt_sel;
  logic [1:0] cap_src;
  logic [1:0] cap_prev_ff;
  logic [1:0] edge_ev;

  always_comb begin
    nxt_sel = sel_ff;
    if (sel_wr_i) begin
      nxt_sel = sel_wdata_i;
    end
    cap_src = pin_s2_ff[1:0];
    // uart lines let the timer time a received break and sync field
    if (CHANNEL == 1) begin
      if (sel_ff[timer_capture_output_sync_pkg::SEL_CH1_IN0_BIT]) begin
        cap_src[0] = pin_s2_ff[2];
      end
      if (sel_ff[timer_capture_output_sync_pkg::SEL_CH1_IN1_BIT]) begin
        cap_src[1] = pin_s2_ff[3];
      end
    end
    // interval match is on our clock, so it bypasses the synchroniser
    if (CHANNEL == 0 && sel_ff[timer_capture_output_sync_pkg::SEL_CH0_IN1_BIT]) begin
      cap_src[1] = interval_match_signal_i;
    end
    edge_ev[0] = edge_hit(edge_sel_0_i, cap_prev_ff[0], cap_src[0]);
    edge_ev[1] = edge_hit(edge_sel_1_i, cap_prev_ff[1], cap_src[1]);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
      cap_prev_ff <= 2'h0;
      sel_ff <= timer_capture_output_sync_pkg::SEL_RST;
    end else begin
      pin_s1_ff <= {uart_receive_1_i, uart_receive_0_i, capture_pin_1_i, capture_pin_0_i};
      pin_s2_ff <= pin_s1_ff;
      cap_prev_ff <= cap_src;
      sel_ff <= nxt_sel;
    end
  end

  // ---------------------------------------------------------------
  // counter, capture and overflow
  // ---------------------------------------------------------------
  run_e state_ff;
  run_e nxt_state;
  logic counted_ff;
  logic nxt_counted;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [15:0] ccr_ff [2];
  logic [15:0] nxt_ccr [2];
  logic ovf_ff;
  logic nxt_ovf;
  logic ovf_irq_ff;
  logic [1:0] cap_irq_ff;
  logic match_ff;
  logic [6:0] opt_ff;
  logic [6:0] nxt_opt;
  logic running;
  logic tick;
  logic pw_mode;
  logic [1:0] cap_ev;
  logic match0;
  logic match1;
  logic ovf_ev;
  logic clr_req;
  logic tuned;
  logic [1:0] prog_copy;
  logic pwm_copy;
  logic start;

  always_comb begin
    running = (state_ff == ST_RUN);
    tick = running && count_tick_i;
    pw_mode = (mode_select_field_i == timer_capture_output_sync_pkg::MODE_PULSE_WIDTH);
    start = (state_ff == ST_STOP) && count_enable_bit_i;
    match0 = tick && counted_ff && (cnt_ff == ccr_ff[0]);
    match1 = tick && counted_ff && (cnt_ff == ccr_ff[1]);
    for (int m = 0; m < 2; m++) begin
      cap_ev[m] = running && edge_ev[m] &&
                  (pw_mode || (mode_select_field_i == timer_capture_output_sync_pkg::MODE_FREE &&
                  ccr_is_capture_i[m]));
    end
    ovf_ev = tick && counted_ff && (cnt_ff == timer_capture_output_sync_pkg::CNT_MAX) && !(|cap_ev) &&
             (pw_mode || mode_select_field_i == timer_capture_output_sync_pkg::MODE_FREE);
    // tuned copies only reach a slave whose sync bit is set
    tuned = IS_SLAVE && sync_enable_bit_i &&
            master_mode_i != timer_capture_output_sync_pkg::MODE_TRIANGLE;
    for (int m = 0; m < 2; m++) begin
      prog_copy[m] = tuned && master_mode_i == timer_capture_output_sync_pkg::MODE_FREE &&
                    master_ccr_wr_i[m];
    end
    pwm_copy = tuned && master_mode_i == timer_capture_output_sync_pkg::MODE_PWM && master_match_i;
    clr_req = ovf_bit_clr_i || (opt_wr_i && !opt_wdata_i[timer_capture_output_sync_pkg::OPT_FLAG_BIT]);

    nxt_state = count_enable_bit_i ? ST_RUN : ST_STOP;
    nxt_counted = running && count_enable_bit_i && (counted_ff || tick);
    nxt_cnt = cnt_ff;
    if (!count_enable_bit_i) begin
      nxt_cnt = timer_capture_output_sync_pkg::CNT_MAX;
    end else if (pw_mode && (|cap_ev)) begin
      nxt_cnt = timer_capture_output_sync_pkg::CNT_ZERO;
    end else if (tick) begin
      if (match0 && !pw_mode && mode_select_field_i != timer_capture_output_sync_pkg::MODE_FREE) begin
        nxt_cnt = timer_capture_output_sync_pkg::CNT_ZERO;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end
    for (int m = 0; m < 2; m++) begin
      nxt_ccr[m] = ccr_ff[m];
      if (cap_ev[m]) begin
        nxt_ccr[m] = cnt_ff;
      end else if (prog_copy[m]) begin
        nxt_ccr[m] = master_wdata_i;
      end else if (pwm_copy) begin
        nxt_ccr[m] = (m == 0) ? master_ccr_0_i : master_ccr_1_i;
      end else if (ccr_wr_i[m]) begin
        nxt_ccr[m] = ccr_wdata_i;
      end
    end
    // set has priority so a clear racing an overflow loses nothing
    nxt_ovf = ovf_ev || (ovf_ff && !clr_req);
    nxt_opt = opt_wr_i ? opt_wdata_i[7:1] : opt_ff;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_ff <= ST_STOP;
      counted_ff <= 1'b0;
      cnt_ff <= timer_capture_output_sync_pkg::CNT_MAX;
      ccr_ff[0] <= timer_capture_output_sync_pkg::CCR_RST;
      ccr_ff[1] <= timer_capture_output_sync_pkg::CCR_RST;
      ovf_ff <= 1'b0;
      ovf_irq_ff <= 1'b0;
      cap_irq_ff <= 2'h0;
      match_ff <= 1'b0;
      opt_ff <= timer_capture_output_sync_pkg::OPT_RST[7:1];
    end else begin
      state_ff <= nxt_state;
      counted_ff <= nxt_counted;
      cnt_ff <= nxt_cnt;
      ccr_ff[0] <= nxt_ccr[0];
      ccr_ff[1] <= nxt_ccr[1];
      ovf_ff <= nxt_ovf;
      ovf_irq_ff <= ovf_ev;
      cap_irq_ff <= cap_ev;
      match_ff <= match0;
      opt_ff <= nxt_opt;
    end
  end

  // ---------------------------------------------------------------
  // output control
  // ---------------------------------------------------------------
  logic [1:0] wave_ff;
  logic [1:0] nxt_wave;
  logic [1:0] pin_ff;
  logic [1:0] nxt_pin;

  always_comb begin
    nxt_wave = wave_ff;
    if (!running) begin
      // waves rise at count start: low before counting, high after
      nxt_wave = start ? 2'h3 : 2'h0;
    end else begin
      case (mode_select_field_i)
        timer_capture_output_sync_pkg::MODE_INTERVAL,
        timer_capture_output_sync_pkg::MODE_EVENT: begin
          nxt_wave[1] = wave_ff[1] ^ match0;
        end
        timer_capture_output_sync_pkg::MODE_TRIGGER: begin
          nxt_wave[1] = match1 ? 1'b1 : (match0 ? 1'b0 : wave_ff[1]);
          nxt_wave[0] = wave_ff[0] ^ match0;
        end
        timer_capture_output_sync_pkg::MODE_ONESHOT,
        timer_capture_output_sync_pkg::MODE_PWM: begin
          nxt_wave[1] = match1 ? 1'b1 : (match0 ? 1'b0 : wave_ff[1]);
          if (mode_select_field_i == timer_capture_output_sync_pkg::MODE_PWM) begin
            nxt_wave[0] = tuned ? nxt_wave[1] : (wave_ff[0] ^ match0);
          end
        end
        timer_capture_output_sync_pkg::MODE_FREE: begin
          nxt_wave[0] = wave_ff[0] ^ (match0 && !ccr_is_capture_i[0]);
          nxt_wave[1] = wave_ff[1] ^ (match1 && !ccr_is_capture_i[1]);
        end
        default: nxt_wave = wave_ff;
      endcase
    end
    for (int m = 0; m < 2; m++) begin
      if (pw_mode) begin
        nxt_pin[m] = 1'b0;
      end else if (output_enable_bit_i[m] && count_enable_bit_i) begin
        nxt_pin[m] = nxt_wave[m] ^ output_level_bit_i[m];
      end else begin
        nxt_pin[m] = output_level_bit_i[m];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wave_ff <= 2'h0;
      pin_ff <= 2'h0;
    end else begin
      wave_ff <= nxt_wave;
      pin_ff <= nxt_pin;
    end
  end

  assign timer_output_0_o = pin_ff[0];
  assign timer_output_1_o = pin_ff[1];
  assign capcmp_reg_0_o = ccr_ff[0];
  assign capcmp_reg_1_o = ccr_ff[1];
  assign counter_read_buffer_o = cnt_ff;
  assign overflow_flag_o = ovf_ff;
  assign overflow_interrupt_o = ovf_irq_ff;
  assign capture_irq_o = cap_irq_ff;
  assign compare_match_o = match_ff;
  assign option_reg_o = {opt_ff, ovf_ff};
  assign capture_source_select_reg_o = sel_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  a_capture_load: assert property (cap_ev[0] |=> capcmp_reg_0_o == $past(cnt_ff))
    else $error("capture did not load counter");
  a_pw_clear: assert property (pw_mode && cap_ev[1] && count_enable_bit_i |=>
    counter_read_buffer_o == 16'h0000 && capture_irq_o[1])
    else $error("pulse width capture did not clear counter");
  a_ovf_set_wins: assert property (ovf_ev |=> overflow_flag_o && overflow_interrupt_o)
    else $error("overflow lost");
  a_ovf_clear_works: assert property (clr_req && !ovf_ev |=> !overflow_flag_o)
    else $error("overflow flag not cleared");
  a_ovf_wrap_zero: assert property (ovf_ev && count_enable_bit_i |=> counter_read_buffer_o == 16'h0000)
    else $error("counter did not wrap");
  a_pw_pins_quiet: assert property (pw_mode |=> !timer_output_0_o && !timer_output_1_o)
    else $error("output driven in pulse width mode");
  a_static_level: assert property (!pw_mode && !output_enable_bit_i[1] |=>
    timer_output_1_o == $past(output_level_bit_i[1]))
    else $error("static output level wrong");
  a_start_invert: assert property (start && !pw_mode && output_enable_bit_i[0] ##0 output_level_bit_i[0] |=>
    !timer_output_0_o)
    else $error("inverted output not low after start");
  a_prog_copy_now: assert property (prog_copy[1] && !cap_ev[1] |=> capcmp_reg_1_o == $past(master_wdata_i))
    else $error("tuned write copy missing");
  a_sel_reset: assert property ($rose(nrst_i) |-> capture_source_select_reg_o == 8'h00)
    else $error("selector not reset");

  c_capture: cover property (cap_ev[0] ##1 capture_irq_o[0]);
  c_overflow: cover property (ovf_ev ##1 overflow_flag_o);
  c_tuned_pwm: cover property (pwm_copy);
  c_set_clear_race: cover property (ovf_ev && clr_req);
endmodule

// File: testbench/pulse_sources.sv
// model of the pins and peer lines that feed the timer channel capture inputs
`timescale 1ns/1ps
module pulse_sources (
  input wire logic clk_sys_i,
  input wire logic [4:0] level_i,
  output logic capture_pin_0_o,
  output logic capture_pin_1_o,
  output logic uart_receive_0_o,
  output logic uart_receive_1_o,
  output logic interval_match_signal_o
);
  // -------------------------------------------------------------
  // line drivers
  // -------------------------------------------------------------
  logic [4:0] line_ff;
  // lines rest low until commanded, so a peer is quiet while the selector changes
  initial line_ff = 5'h00;
  always @(posedge clk_sys_i) begin
    line_ff <= level_i;
  end
  assign capture_pin_0_o = line_ff[0];
  assign capture_pin_1_o = line_ff[1];
  assign uart_receive_0_o = line_ff[2];
  assign uart_receive_1_o = line_ff[3];
  assign interval_match_signal_o = line_ff[4];
endmodule

// File: testbench/tb_top.sv
// self-checking bench for one timer channel, acting as slave channel 1
`timescale 1ns/1ps
module tb_top;
  // -------------------------------------------------------------
  // stimulus, instances and reporting
  // -------------------------------------------------------------
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, en = 1'b0, tck = 1'b0, opt_wr = 1'b0, clr = 1'b0, sel_wr = 1'b0;
  logic sye = 1'b0, mmatch = 1'b0, to0, to1, flag, ovi, cm, p0, p1, u0, u1, im;
  logic [2:0] mode = 3'h0, mmode = 3'h0;
  logic [1:0] oe = 2'h0, ol = 2'h0, es0 = 2'h0, es1 = 2'h0, cap = 2'h0, ccr_wr = 2'h0, mwr = 2'h0, cirq;
  logic [15:0] ccr_wd = 16'h0000, mwd = 16'h0000, m0 = 16'h0000, m1 = 16'h0000, cc0, cc1, cnt;
  logic [7:0] opt_wd = 8'h00, sel_wd = 8'h00, opt, sel;
  logic [4:0] lvl = 5'h00;
  logic seen, hit;
  int errors = 0, checks = 0, cycles = 0, i;
  always #5 clk_sys_i = ~clk_sys_i;
  pulse_sources src (.clk_sys_i(clk_sys_i), .level_i(lvl), .capture_pin_0_o(p0), .capture_pin_1_o(p1),
    .uart_receive_0_o(u0), .uart_receive_1_o(u1), .interval_match_signal_o(im));
  timer_capture_output_sync #(.CHANNEL(1)) dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .count_enable_bit_i(en), .count_tick_i(tck), .mode_select_field_i(mode), .output_enable_bit_i(oe),
    .output_level_bit_i(ol), .edge_sel_0_i(es0), .edge_sel_1_i(es1), .ccr_is_capture_i(cap),
    .capture_pin_0_i(p0), .capture_pin_1_i(p1), .uart_receive_0_i(u0), .uart_receive_1_i(u1),
    .interval_match_signal_i(im), .ccr_wr_i(ccr_wr), .ccr_wdata_i(ccr_wd), .opt_wr_i(opt_wr),
    .opt_wdata_i(opt_wd), .ovf_bit_clr_i(clr), .sel_wr_i(sel_wr), .sel_wdata_i(sel_wd),
    .sync_enable_bit_i(sye), .master_mode_i(mmode), .master_ccr_wr_i(mwr), .master_wdata_i(mwd),
    .master_match_i(mmatch), .master_ccr_0_i(m0), .master_ccr_1_i(m1), .timer_output_0_o(to0),
    .timer_output_1_o(to1), .capcmp_reg_0_o(cc0), .capcmp_reg_1_o(cc1), .counter_read_buffer_o(cnt),
    .overflow_flag_o(flag), .overflow_interrupt_o(ovi), .capture_irq_o(cirq), .compare_match_o(cm),
    .option_reg_o(opt), .capture_source_select_reg_o(sel));
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // bounded wait for a capture pulse on input 0, sampled after each edge settles
  task wait_cap(input int n);
    seen = 1'b0;
    for (i = 0; i < n && !seen; i++) begin
      cyc(1);
      #1 seen = (cirq[0] === 1'b1);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // the overflow wait alone needs some 65600 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      give_verdict();
    end
  end
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task t_outputs;
    ccr_wr <= 2'h1;
    ccr_wd <= 16'h0008;
    for (i = 0; i < 8; i++) begin
      cyc(1);
      ccr_wr <= 2'h0;
      oe <= i[2] ? 2'h3 : 2'h0;
      ol <= i[1:0];
      cyc(3);
      #1 chk("pins stopped", {14'h0000, to1, to0}, {14'h0000, i[1:0]});
    end
    cyc(1);
    ol <= 2'h2;
    en <= 1'b1;
    cyc(4);
    #1 chk("pin0 level0 running", {15'h0000, to0}, 16'h0001);
    chk("pin1 level1 running", {15'h0000, to1}, 16'h0000);
    cyc(1);
    tck <= 1'b1;
    seen = 1'b0;
    hit = 1'b0;
    repeat (30) begin
      cyc(1);
      #1 if (to1 !== 1'b0) seen = 1'b1;
      if (cm === 1'b1) hit = 1'b1;
    end
    chk("interval square wave", {15'h0000, seen}, 16'h0001);
    chk("compare match pulse", {15'h0000, hit}, 16'h0001);
    cyc(1);
    tck <= 1'b0;
    en <= 1'b0;
    $display("test outputs done");
  endtask
  task t_capture;
    cyc(2);
    mode <= timer_capture_output_sync_pkg::MODE_PULSE_WIDTH;
    es0 <= timer_capture_output_sync_pkg::EDGE_RISE;
    oe <= 2'h3;
    ol <= 2'h3;
    en <= 1'b1;
    cyc(3);
    tck <= 1'b1;
    cyc(5);
    tck <= 1'b0;
    cyc(2);
    #1 chk("read buffer", cnt, 16'h0004);
    chk("pins in pulse width", {14'h0000, to1, to0}, 16'h0000);
    cyc(1);
    lvl <= 5'h01;
    wait_cap(12);
    chk("capture irq", {15'h0000, seen}, 16'h0001);
    chk("captured value", cc0, 16'h0004);
    chk("counter cleared", cnt, 16'h0000);
    cyc(1);
    lvl <= 5'h00;
    en <= 1'b0;
    $display("test capture done");
  endtask
  task t_selector;
    cyc(2);
    sel_wr <= 1'b1; // peer lines idle while the route changes
    sel_wd <= 8'h18;
    es1 <= timer_capture_output_sync_pkg::EDGE_RISE;
    cyc(1);
    sel_wr <= 1'b0;
    en <= 1'b1;
    cyc(4);
    lvl <= 5'h01;
    wait_cap(10);
    chk("pin ignored", {15'h0000, seen}, 16'h0000);
    chk("selector reg", {8'h00, sel}, 16'h0018);
    cyc(1);
    lvl <= 5'h0d;
    wait_cap(12);
    chk("uart capture", {15'h0000, seen}, 16'h0001);
    chk("uart1 capture irq", {15'h0000, cirq[1]}, 16'h0001);
    chk("uart captured value", cc0, 16'hffff);
    chk("uart1 captured value", cc1, 16'hffff);
    cyc(1);
    lvl <= 5'h00;
    en <= 1'b0;
    es0 <= timer_capture_output_sync_pkg::EDGE_NONE;
    es1 <= timer_capture_output_sync_pkg::EDGE_NONE;
    $display("test selector done");
  endtask
  task t_tuned;
    cyc(1);
    mode <= timer_capture_output_sync_pkg::MODE_FREE;
    sye <= 1'b1; // slave in free-run with sync set
    mmode <= timer_capture_output_sync_pkg::MODE_FREE;
    mwr <= 2'h3;
    mwd <= 16'h1234;
    cyc(1);
    mwr <= 2'h0;
    cyc(1);
    #1 chk("copy at write", cc0, 16'h1234);
    chk("copy at write 1", cc1, 16'h1234);
    cyc(1);
    mmode <= timer_capture_output_sync_pkg::MODE_TRIANGLE;
    mwr <= 2'h2;
    mwd <= 16'h4321;
    cyc(1);
    mwr <= 2'h0;
    cyc(1);
    #1 chk("no triangle copy", cc1, 16'h1234);
    cyc(1);
    mmode <= timer_capture_output_sync_pkg::MODE_PWM;
    m0 <= 16'haaaa;
    m1 <= 16'h5555;
    mmatch <= 1'b1;
    cyc(1);
    mmatch <= 1'b0;
    cyc(1);
    #1 chk("match copy 0", cc0, 16'haaaa);
    chk("match copy 1", cc1, 16'h5555);
    cyc(1);
    sye <= 1'b0;
    $display("test tuned done");
  endtask
  task t_overflow;
    cyc(1);
    en <= 1'b1; // slave started earlier than any master
    tck <= 1'b1;
    seen = 1'b0;
    for (i = 0; i < 70000 && !seen; i++) begin
      cyc(1);
      #1 seen = (cnt === 16'hfffe);
    end
    cyc(1);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    tck <= 1'b0;
    #1 chk("flag kept over clear", {15'h0000, flag}, 16'h0001);
    chk("overflow irq", {15'h0000, ovi}, 16'h0001);
    chk("wrapped counter", cnt, 16'h0000);
    chk("free-run compare waves", {14'h0000, to1, to0}, 16'h0003);
    cyc(1);
    opt_wr <= 1'b1;
    opt_wd <= 8'h01;
    cyc(1);
    opt_wr <= 1'b0;
    cyc(1);
    #1 chk("flag confirmed set", {15'h0000, flag}, 16'h0001);
    chk("option reg", {8'h00, opt}, 16'h0001);
    cyc(1);
    opt_wr <= 1'b1;
    opt_wd <= 8'hfe;
    cyc(1);
    opt_wr <= 1'b0;
    cyc(1);
    #1 chk("flag cleared", {15'h0000, flag}, 16'h0000);
    chk("option stored", {8'h00, opt}, 16'h00fe);
    $display("test overflow done");
  endtask
  initial begin
    cyc(8);
    nrst_i <= 1'b1;
    cyc(1);
    #1 chk("reset counter", cnt, 16'hffff);
    chk("reset selector", {8'h00, sel}, 16'h0000);
    cyc(1);
    t_outputs();
    t_capture();
    t_selector();
    t_tuned();
    t_overflow();
    give_verdict();
  end
endmodule
